/* logic/bwc_pkg.sv */
// package for the bridge window configuration register slice
// assumes an axi4-lite register bus clocked by aclk with synchronous active-low reset
package bwc_pkg;
  localparam logic [7:0]  off_pf_base_hi  = 8'h28;
  localparam logic [7:0]  off_pf_limit_hi = 8'h2c;
  localparam logic [7:0]  off_io_hi       = 8'h30;
  localparam logic [7:0]  off_cap_ptr     = 8'h34;
  localparam logic [7:0]  off_intr_ctl    = 8'h3c;
  localparam logic [7:0]  cap_ptr_value   = 8'h80;
  localparam logic [7:0]  intr_pin_value  = 8'h00;
  localparam logic [31:0] rst_word        = 32'h0000_0000;
  localparam logic [15:0] rst_half        = 16'h0000;
  localparam logic [7:0]  rst_intr_line   = 8'h00;
  localparam int          bit_par_resp    = 16;
  localparam int          bit_serr_fwd    = 17;
  localparam int          bit_isa_filter  = 18;
  localparam logic [1:0]  resp_okay       = 2'b00;
  localparam logic [1:0]  resp_slverr     = 2'b10;
  localparam logic [19:0] limit_low_ones  = 20'hfffff;
  localparam logic [19:0] base_low_zeros  = 20'h00000;

  typedef struct packed {
    logic [31:0] pf_base_hi;
    logic [31:0] pf_limit_hi;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit_hi;
    logic [7:0]  intr_line;
    logic        par_resp;
    logic        serr_fwd;
    logic        isa_filter;
  } bwc_cfg_t;

  typedef enum logic [1:0] {
    bwc_idle = 2'b00,
    bwc_resp = 2'b01
  } bwc_wstate_t;
endpackage

/* logic/bwc_window_decode.sv */
// combinational forwarding decode for prefetchable memory and I/O windows
// assumes address inputs and lower bound fields come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module bwc_window_decode
(
  input  wire logic              [63:0] mem_addr,
  input  wire logic              [11:0] pf_base_lo,
  input  wire logic              [11:0] pf_limit_lo,
  input  wire logic              [31:0] io_addr,
  input  wire logic              [15:0] io_base_lo,
  input  wire logic              [15:0] io_limit_lo,
  input  wire bwc_pkg::bwc_cfg_t        cfg,
  output logic                          mem_hit,
  output logic                          io_hit,
  output logic                          io_isa_block
);
  logic [63:0] pf_base;
  logic [63:0] pf_limit;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  logic        io_in_window;
  logic        io_isa_alias;

  always_comb
  begin
    pf_base  = {cfg.pf_base_hi, pf_base_lo, bwc_pkg::base_low_zeros};
    pf_limit = {cfg.pf_limit_hi, pf_limit_lo, bwc_pkg::limit_low_ones};
    mem_hit  = (mem_addr >= pf_base) && (mem_addr <= pf_limit);
    io_base  = {cfg.io_base_hi, io_base_lo};
    io_limit = {cfg.io_limit_hi, io_limit_lo};
    io_in_window = (io_addr >= io_base) && (io_addr <= io_limit);
    // last 768 bytes of a 1KB block means address bits 9:8 nonzero
    io_isa_alias = (io_addr[31:16] == 16'h0000) && (io_addr[9:8] != 2'b00);
    io_isa_block = cfg.isa_filter && io_in_window && io_isa_alias;
    io_hit       = io_in_window && !io_isa_block;
  end
endmodule
`default_nettype wire

/* logic/bwc_config_regs.sv */
// axi4-lite register slice of a bridge configuration header, offsets 28h to 3Ch
// assumes a single axi4-lite master on aclk; decode inputs from same-clock forwarding logic
`timescale 1ns/1ps
`default_nettype none
module bwc_config_regs
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [63:0] mem_addr,
  input  wire logic [11:0] pf_base_lo,
  input  wire logic [11:0] pf_limit_lo,
  input  wire logic [31:0] io_addr,
  input  wire logic [15:0] io_base_lo,
  input  wire logic [15:0] io_limit_lo,
  input  wire logic        sec_parity_err,
  input  wire logic        secondary_system_error_n,
  output logic             mem_forward,
  output logic             io_forward,
  output logic             io_upstream,
  output logic             sec_parity_report,
  output logic             pri_system_error_req,
  output logic             parity_resp_en,
  output logic             serr_forward_en,
  output logic             isa_filter_en
);
  bwc_pkg::bwc_cfg_t    cfg;
  bwc_pkg::bwc_cfg_t    next_cfg;
  bwc_pkg::bwc_wstate_t wstate;
  bwc_pkg::bwc_wstate_t next_wstate;
  logic                 aw_held;
  logic                 next_aw_held;
  logic                 w_held;
  logic                 next_w_held;
  logic [7:0]           aw_addr;
  logic [7:0]           next_aw_addr;
  logic [31:0]          w_data;
  logic [31:0]          next_w_data;
  logic [3:0]           w_strb;
  logic [3:0]           next_w_strb;
  logic [1:0]           bresp;
  logic [1:0]           next_bresp;
  logic                 rvalid;
  logic                 next_rvalid;
  logic [31:0]          rdata;
  logic [31:0]          next_rdata;
  logic [1:0]           rresp;
  logic [1:0]           next_rresp;
  logic                 serr_s1;
  logic                 serr_s2;
  logic                 par_s1;
  logic                 par_s2;
  logic                 mem_hit;
  logic                 io_hit;
  logic                 io_isa_block;
  logic                 next_awready;
  logic                 next_wready;
  logic                 next_bvalid;
  logic                 next_arready;

  // byte-lane merge used for every writable word
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[7:2] == bwc_pkg::off_pf_base_hi[7:2]) || (a[7:2] == bwc_pkg::off_pf_limit_hi[7:2]) ||
           (a[7:2] == bwc_pkg::off_io_hi[7:2]) || (a[7:2] == bwc_pkg::off_cap_ptr[7:2]) ||
           (a[7:2] == bwc_pkg::off_intr_ctl[7:2]);
  endfunction

  function automatic logic [31:0] ctl_word(input bwc_pkg::bwc_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[7:0]                    = c.intr_line;
    w[15:8]                   = bwc_pkg::intr_pin_value;
    w[bwc_pkg::bit_par_resp]   = c.par_resp;
    w[bwc_pkg::bit_serr_fwd]   = c.serr_fwd;
    w[bwc_pkg::bit_isa_filter] = c.isa_filter;
    return w;
  endfunction

  // write channel: address and data captured in either order, then one response
  always_comb
  begin
    logic [31:0] m;
    logic        do_write;
    m            = 32'h0000_0000;
    next_cfg     = cfg;
    next_wstate  = wstate;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bresp   = bresp;
    do_write     = 1'b0;
    unique case (wstate)
      bwc_pkg::bwc_idle:
      begin
        if (s_axi_awvalid && !aw_held)
        begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held)
        begin
          next_w_held = 1'b1;
          next_w_data = s_axi_wdata;
          next_w_strb = s_axi_wstrb;
        end
        if (next_aw_held && next_w_held)
        begin
          do_write     = 1'b1;
          next_wstate  = bwc_pkg::bwc_resp;
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_bresp   = mapped(next_aw_addr) ? bwc_pkg::resp_okay : bwc_pkg::resp_slverr;
        end
      end
      bwc_pkg::bwc_resp:
      begin
        if (s_axi_bready)
        begin
          next_wstate = bwc_pkg::bwc_idle;
        end
      end
    endcase
    // readies come from flops too, so no bus output has a gate after its register
    next_awready = (next_wstate == bwc_pkg::bwc_idle) && !next_aw_held;
    next_wready  = (next_wstate == bwc_pkg::bwc_idle) && !next_w_held;
    next_bvalid  = (next_wstate == bwc_pkg::bwc_resp);
    if (do_write)
    begin
      case (next_aw_addr[7:2])
        bwc_pkg::off_pf_base_hi[7:2]:
        begin
          next_cfg.pf_base_hi = merge_lanes(cfg.pf_base_hi, next_w_data, next_w_strb);
        end
        bwc_pkg::off_pf_limit_hi[7:2]:
        begin
          next_cfg.pf_limit_hi = merge_lanes(cfg.pf_limit_hi, next_w_data, next_w_strb);
        end
        bwc_pkg::off_io_hi[7:2]:
        begin
          m = merge_lanes({cfg.io_limit_hi, cfg.io_base_hi}, next_w_data, next_w_strb);
          next_cfg.io_base_hi  = m[15:0];
          next_cfg.io_limit_hi = m[31:16];
        end
        bwc_pkg::off_intr_ctl[7:2]:
        begin
          // pin byte and upper control bits stay fixed; only writable fields are taken
          m = merge_lanes(ctl_word(cfg), next_w_data, next_w_strb);
          next_cfg.intr_line  = m[7:0];
          next_cfg.par_resp   = m[bwc_pkg::bit_par_resp];
          next_cfg.serr_fwd   = m[bwc_pkg::bit_serr_fwd];
          next_cfg.isa_filter = m[bwc_pkg::bit_isa_filter];
        end
        default:
        begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg.pf_base_hi  <= bwc_pkg::rst_word;
      cfg.pf_limit_hi <= bwc_pkg::rst_word;
      cfg.io_base_hi  <= bwc_pkg::rst_half;
      cfg.io_limit_hi <= bwc_pkg::rst_half;
      cfg.intr_line   <= bwc_pkg::rst_intr_line;
      cfg.par_resp    <= 1'b0;
      cfg.serr_fwd    <= 1'b0;
      cfg.isa_filter  <= 1'b0;
      wstate          <= bwc_pkg::bwc_idle;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      bresp           <= bwc_pkg::resp_okay;
      s_axi_awready   <= 1'b1;
      s_axi_wready    <= 1'b1;
      s_axi_bvalid    <= 1'b0;
    end
    else
    begin
      cfg     <= next_cfg;
      wstate  <= next_wstate;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bresp   <= next_bresp;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
    end
  end

  // read channel: one read in flight, answered the cycle after the address is taken
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (!rvalid && s_axi_arvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp  = bwc_pkg::resp_okay;
      case (s_axi_araddr[7:2])
        bwc_pkg::off_pf_base_hi[7:2]:  next_rdata = cfg.pf_base_hi;
        bwc_pkg::off_pf_limit_hi[7:2]: next_rdata = cfg.pf_limit_hi;
        bwc_pkg::off_io_hi[7:2]:       next_rdata = {cfg.io_limit_hi, cfg.io_base_hi};
        bwc_pkg::off_cap_ptr[7:2]:     next_rdata = {24'h000000, bwc_pkg::cap_ptr_value};
        bwc_pkg::off_intr_ctl[7:2]:    next_rdata = ctl_word(cfg);
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = bwc_pkg::resp_slverr;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid        <= 1'b0;
      rdata         <= 32'h0000_0000;
      rresp         <= bwc_pkg::resp_okay;
      s_axi_arready <= 1'b1;
    end
    else
    begin
      rvalid        <= next_rvalid;
      rdata         <= next_rdata;
      rresp         <= next_rresp;
      s_axi_arready <= next_arready;
    end
  end

  bwc_window_decode u_decode
  (
    .mem_addr     (mem_addr),
    .pf_base_lo   (pf_base_lo),
    .pf_limit_lo  (pf_limit_lo),
    .io_addr      (io_addr),
    .io_base_lo   (io_base_lo),
    .io_limit_lo  (io_limit_lo),
    .cfg          (cfg),
    .mem_hit      (mem_hit),
    .io_hit       (io_hit),
    .io_isa_block (io_isa_block)
  );

  // error pins come from the secondary bus, so they pass two flops first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serr_s1       <= 1'b0;
      serr_s2       <= 1'b0;
      par_s1        <= 1'b0;
      par_s2        <= 1'b0;
      mem_forward          <= 1'b0;
      io_forward           <= 1'b0;
      io_upstream          <= 1'b0;
      sec_parity_report    <= 1'b0;
      pri_system_error_req <= 1'b0;
    end
    else
    begin
      serr_s1       <= !secondary_system_error_n;
      serr_s2       <= serr_s1;
      par_s1        <= sec_parity_err;
      par_s2        <= par_s1;
      mem_forward          <= mem_hit;
      io_forward           <= io_hit;
      io_upstream          <= io_isa_block;
      sec_parity_report    <= par_s2 && cfg.par_resp;
      pri_system_error_req <= serr_s2 && cfg.serr_fwd;
    end
  end

  assign s_axi_bresp          = bresp;
  assign s_axi_rvalid         = rvalid;
  assign s_axi_rdata          = rdata;
  assign s_axi_rresp          = rresp;
  assign parity_resp_en       = cfg.par_resp;
  assign serr_forward_en      = cfg.serr_fwd;
  assign isa_filter_en        = cfg.isa_filter;
endmodule
`default_nettype wire

/* verification/bwc_config_regs_assertions.sv */
// checker for the bwc register slice: bus answers and error gating
// assumes bind onto bwc_config_regs, one clock domain
`timescale 1ns/1ps
`default_nettype none
module bwc_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sec_parity_err,
  input wire logic        secondary_system_error_n,
  input wire logic        sec_parity_report,
  input wire logic        pri_system_error_req,
  input wire logic        parity_resp_en,
  input wire logic        serr_forward_en,
  input wire logic        io_forward,
  input wire logic        io_upstream,
  input wire logic        isa_filter_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  write_answer_a: assert property (wr_taken |=> s_axi_bvalid) else $error("no write answer");
  bresp_hold_a: assert property (resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  bus_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data unstable");
  // sync depth may be two or three edges, so either past sample is a cause
  parity_gate_a: assert property (sec_parity_report |-> $past(parity_resp_en) &&
    ($past(sec_parity_err, 3) || $past(sec_parity_err, 4))) else $error("parity report uncaused");
  parity_on_a: assert property (sec_parity_err && parity_resp_en [*5] |-> sec_parity_report)
    else $error("parity report missing");
  serr_gate_a: assert property (pri_system_error_req |-> $past(serr_forward_en) &&
    (!$past(secondary_system_error_n, 3) || !$past(secondary_system_error_n, 4))) else $error("serr uncaused");
  isa_split_a: assert property (io_upstream |-> !io_forward && $past(isa_filter_en))
    else $error("isa address sent both ways or unfiltered");
endmodule
bind bwc_config_regs bwc_checker chk
(
  .aclk (aclk), .aresetn (aresetn), .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
  .s_axi_wvalid (s_axi_wvalid), .s_axi_wready (s_axi_wready), .s_axi_bresp (s_axi_bresp),
  .s_axi_bvalid (s_axi_bvalid), .s_axi_bready (s_axi_bready), .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready), .s_axi_rdata (s_axi_rdata), .s_axi_rvalid (s_axi_rvalid),
  .s_axi_rready (s_axi_rready), .sec_parity_err (sec_parity_err),
  .secondary_system_error_n (secondary_system_error_n), .sec_parity_report (sec_parity_report),
  .pri_system_error_req (pri_system_error_req), .parity_resp_en (parity_resp_en),
  .serr_forward_en (serr_forward_en), .io_forward (io_forward), .io_upstream (io_upstream),
  .isa_filter_en (isa_filter_en)
);
`default_nettype wire

/* verification/bwc_host.sv */
// upstream host model: axi4-lite master issuing configuration accesses
// assumes the bench calls wr and rd one at a time after reset
`timescale 1ns/1ps
`default_nettype none
module bwc_host
(
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} <= {a, 1'b1, d, s};
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      // released payload is scrambled so a stale value never looks valid
      if (s_axi_awvalid && s_axi_awready)
      begin
        ad = 1'b1;
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd = 1'b1;
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end
    end
    // ready raised only after the answer shows, so the slave must hold it a cycle
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(posedge aclk); while (!s_axi_arready);
    {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for bwc_config_regs with the host model
// assumes 250 MHz aclk and the hand-over latencies
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, io_addr, cycles = 0;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [63:0] mem_addr = 64'h0;
  logic [11:0] pf_base_lo = 12'h001, pf_limit_lo = 12'h002;
  logic [15:0] io_base_lo = 16'h0100, io_limit_lo = 16'hffff;
  logic        sec_parity_err = 1'b0, secondary_system_error_n = 1'b1;
  logic        mem_forward, io_forward, io_upstream, sec_parity_report, pri_system_error_req;
  logic        parity_resp_en, serr_forward_en, isa_filter_en;
  int          failures = 0, checks_done = 0;
  bwc_config_regs dut
  (
    .aclk (aclk), .aresetn (aresetn), .s_axi_awaddr (s_axi_awaddr), .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready), .s_axi_wdata (s_axi_wdata), .s_axi_wstrb (s_axi_wstrb),
    .s_axi_wvalid (s_axi_wvalid), .s_axi_wready (s_axi_wready), .s_axi_bresp (s_axi_bresp),
    .s_axi_bvalid (s_axi_bvalid), .s_axi_bready (s_axi_bready), .s_axi_araddr (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid), .s_axi_arready (s_axi_arready), .s_axi_rdata (s_axi_rdata),
    .s_axi_rresp (s_axi_rresp), .s_axi_rvalid (s_axi_rvalid), .s_axi_rready (s_axi_rready),
    .mem_addr (mem_addr), .pf_base_lo (pf_base_lo), .pf_limit_lo (pf_limit_lo), .io_addr (io_addr),
    .io_base_lo (io_base_lo), .io_limit_lo (io_limit_lo), .sec_parity_err (sec_parity_err),
    .secondary_system_error_n (secondary_system_error_n), .mem_forward (mem_forward),
    .io_forward (io_forward), .io_upstream (io_upstream), .sec_parity_report (sec_parity_report),
    .pri_system_error_req (pri_system_error_req), .parity_resp_en (parity_resp_en),
    .serr_forward_en (serr_forward_en), .isa_filter_en (isa_filter_en)
  );
  bwc_host host
  (
    .aclk (aclk), .s_axi_awaddr (s_axi_awaddr), .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready), .s_axi_wdata (s_axi_wdata), .s_axi_wstrb (s_axi_wstrb),
    .s_axi_wvalid (s_axi_wvalid), .s_axi_wready (s_axi_wready), .s_axi_bresp (s_axi_bresp),
    .s_axi_bvalid (s_axi_bvalid), .s_axi_bready (s_axi_bready), .s_axi_araddr (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid), .s_axi_arready (s_axi_arready), .s_axi_rdata (s_axi_rdata),
    .s_axi_rresp (s_axi_rresp), .s_axi_rvalid (s_axi_rvalid), .s_axi_rready (s_axi_rready)
  );
  always #2 aclk = ~aclk;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // run is far below this; reaching it means a handshake hung
  always @(posedge aclk)
  begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'h1388)
    begin
      failures++;
      stop_test;
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic [1:0] r;
    host.wr(a, d, s, r);
    chk("bresp", {30'h0, r}, {30'h0, e});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic t_reset;
    rdc(8'h28, 32'h0, 2'h0);
    rdc(8'h2c, 32'h0, 2'h0);
    rdc(8'h30, 32'h0, 2'h0);
    rdc(8'h34, 32'h0000_0080, 2'h0);
    rdc(8'h3c, 32'h0, 2'h0);
    $display("test reset values done");
  endtask
  task automatic t_regs;
    wrc(8'h28, 32'h89ab_cdef, 4'hf, 2'h0);
    wrc(8'h28, 32'h1122_3344, 4'h5, 2'h0);
    rdc(8'h28, 32'h8922_cd44, 2'h0);
    wrc(8'h2c, 32'hfedc_ba98, 4'hf, 2'h0);
    rdc(8'h2c, 32'hfedc_ba98, 2'h0);
    wrc(8'h30, 32'h5a5a_a5a5, 4'hf, 2'h0);
    rdc(8'h30, 32'h5a5a_a5a5, 2'h0);
    wrc(8'h34, 32'h0000_0011, 4'hf, 2'h0);
    rdc(8'h34, 32'h0000_0080, 2'h0);
    wrc(8'h3c, 32'hffff_ffff, 4'hf, 2'h0);
    rdc(8'h3c, 32'h0007_00ff, 2'h0);
    chk("ctl", {29'h0, isa_filter_en, serr_forward_en, parity_resp_en}, 32'h7);
    wrc(8'h3c, 32'h0000_00ff, 4'hf, 2'h0);
    rdc(8'h3c, 32'h0000_00ff, 2'h0);
    wrc(8'h38, 32'h1, 4'hf, 2'h2);
    rdc(8'h38, 32'h0, 2'h2);
    $display("test register access done");
  endtask
  task automatic t_mem;
    logic [63:0] a [5] = '{64'h1_0010_0000, 64'h1_002f_ffff, 64'h1_0030_0000, 64'h1_000f_ffff, 64'h2_0010_0000};
    logic        e [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    wrc(8'h28, 32'h1, 4'hf, 2'h0);
    wrc(8'h2c, 32'h1, 4'hf, 2'h0);
    for (int i = 0; i < 5; i++)
    begin
      mem_addr <= a[i];
      repeat (2) @(posedge aclk);
      chk("mem_forward", {31'h0, mem_forward}, {31'h0, e[i]});
    end
    $display("test prefetch window done");
  endtask
  task automatic t_io;
    logic [31:0] a [7] = '{32'h0500, 32'h00ff, 32'h0500, 32'h0400, 32'h04ff, 32'h1_0500, 32'h2_0500};
    logic [1:0]  e [7] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0};
    wrc(8'h30, 32'h0001_0000, 4'hf, 2'h0);
    for (int i = 0; i < 7; i++)
    begin
      if (i == 2)
        wrc(8'h3c, 32'h0004_00ff, 4'hf, 2'h0);
      io_addr <= a[i];
      repeat (2) @(posedge aclk);
      chk("io fwd up", {30'h0, io_forward, io_upstream}, {30'h0, e[i]});
    end
    $display("test io window done");
  endtask
  task automatic t_err;
    wrc(8'h3c, 32'h0000_00ff, 4'hf, 2'h0);
    {sec_parity_err, secondary_system_error_n} <= 2'b10;
    repeat (6) @(posedge aclk);
    chk("err gated", {30'h0, sec_parity_report, pri_system_error_req}, 32'h0);
    wrc(8'h3c, 32'h0003_00ff, 4'hf, 2'h0);
    repeat (6) @(posedge aclk);
    chk("err sent", {30'h0, sec_parity_report, pri_system_error_req}, 32'h3);
    {sec_parity_err, secondary_system_error_n} <= 2'b01;
    repeat (6) @(posedge aclk);
    chk("err gone", {30'h0, sec_parity_report, pri_system_error_req}, 32'h0);
    $display("test error gating done");
  endtask
  initial
  begin
    io_addr = 32'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_regs;
    t_mem;
    t_io;
    t_err;
    stop_test;
  end
endmodule
`default_nettype wire
